// ==== common/asr_pkg.sv ====
// constants and types for the converter serial register access block
package asr_pkg;
  // frame geometry
  localparam int FRAME_BITS = 16;
  localparam int CRC_BITS = 8;
  localparam int EXT_BITS = FRAME_BITS + CRC_BITS;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;
  localparam logic [CNT_W-1:0] CNT_CMD_LAST = 6'h0F;
  localparam logic [CNT_W-1:0] CNT_CRC_LAST = 6'h17;
  // command word fields
  localparam int CMD_POS = 15;
  localparam int SEL_HI = 14;
  localparam int SEL_LO = 12;
  localparam int DATA_W = 12;
  // first setup register
  localparam logic [2:0] SETUP_ONE_SEL = 3'h1;
  localparam logic [3:0] SETUP_ONE_TAG = 4'h1;
  localparam logic [11:0] SETUP_ONE_RST = 12'h000;
  localparam logic [11:0] SETUP_ONE_WMASK = 12'h3FF;
  localparam int RAE_POS = 9;
  localparam int RATIO_HI = 8;
  localparam int RATIO_LO = 6;
  localparam int CRC_IN_POS = 5;
  localparam int CRC_OUT_POS = 4;
  localparam int ALARM_EN_POS = 3;
  localparam int BOOST_POS = 2;
  localparam int REF_POS = 1;
  localparam int PDN_POS = 0;
  // averaging ratio codes
  localparam logic [2:0] RATIO_OFF = 3'h0;
  localparam logic [2:0] RATIO_X2 = 3'h1;
  localparam logic [2:0] RATIO_X4 = 3'h2;
  localparam logic [2:0] RATIO_X8 = 3'h3;
  // crc-8 generator, zero seed
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  // outgoing shift widths
  localparam int TX_A_W = 2 * FRAME_BITS + CRC_BITS;
  localparam int TX_B_W = EXT_BITS;
  localparam logic [2:0] SYNC_RST = 3'h1;
  typedef enum logic [1:0] {ACT_IGNORE, ACT_WRITE, ACT_READ, ACT_CONV} asr_action_t;
endpackage

// ==== test/asr_host_model.sv ====
// behavioural serial host that sends command frames
`timescale 1ns/1ps
module asr_host_model (
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic primary_data_out,
  input wire logic secondary_out_or_alarm
);
  // link clock stands low between frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b0;
    sdi = 1'b1;
    // a definite rising select edge clears the far bit counter
    #1 cs_n = 1'b1;
  end
  // n edges, msb first; outputs taken at the end of each low phase
  task automatic xfer(input logic [23:0] w, input int n, output logic [31:0] ra,
      output logic [31:0] rb);
    ra = '0;
    rb = '0;
    #1.3;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi = (i < 24) ? w[23-i] : 1'b0;
      #62.5;
      ra = {ra[30:0], primary_data_out};
      rb = {rb[30:0], secondary_out_or_alarm};
      sclk = 1'b1;
      #62.5;
      sclk = 1'b0;
    end
    cs_n = 1'b1;
    sdi = ~sdi; // released line must not look held
  endtask
endmodule

// ==== test/asr_reg_access_props.sv ====
// assertion checker for the serial register access block
`timescale 1ns/1ps
module asr_reg_access_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic output_wire_count,
  input wire logic [11:0] setup_one,
  input wire logic rolling_average_enable,
  input wire logic [2:0] averaging_ratio,
  input wire logic averaging_active,
  input wire logic [1:0] averaging_shift,
  input wire logic crc_in_enable,
  input wire logic crc_out_enable,
  input wire logic alarm_on_secondary,
  input wire logic resolution_boost,
  input wire logic reference_source,
  input wire logic power_down_select,
  input wire logic frame_done,
  input wire logic frame_ignored
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // end pulses of accepted and of dropped frames
  sequence good_end;
    frame_done && !frame_ignored;
  endsequence
  sequence dropped_end;
    frame_done && frame_ignored;
  endsequence
  // control copies lag the register by one cycle
  rsv_bits_a: assert property (setup_one[11:10] == 2'h0)
    else $error("reserved setup bits set");
  ratio_copy_a: assert property (
    averaging_ratio == $past(setup_one[8:6])) else $error("ratio copy wrong");
  avg_gate_a: assert property (
    averaging_active == ($past(setup_one[9]) && $past(setup_one[8:6]) inside {[1:3]})
    && rolling_average_enable == $past(setup_one[9])) else $error("averaging gate wrong");
  avg_shift_a: assert property (
    averaging_shift == ($past(setup_one[8]) ? 2'h0 : $past(setup_one[7:6])))
    else $error("averaging shift wrong");
  boost_gate_a: assert property (
    resolution_boost == ($past(setup_one[2]) && $past(setup_one[8:6]) != 3'h0))
    else $error("boost gate wrong");
  alarm_gate_a: assert property (
    alarm_on_secondary == ($past(setup_one[3]) && $past(output_wire_count)))
    else $error("alarm gate wrong");
  crc_copy_a: assert property (
    {crc_in_enable, crc_out_enable} == $past(setup_one[5:4])) else $error("crc copy wrong");
  ref_pdn_a: assert property (
    {reference_source, power_down_select} == $past(setup_one[1:0]))
    else $error("ref or power copy wrong");
  // the register moves only at the end of an accepted frame
  // register and end pulse are launched by the same clock edge
  write_at_end_a: assert property ($changed(setup_one) |-> good_end)
    else $error("setup changed outside frame end");
  drop_keeps_a: assert property (dropped_end |-> $stable(setup_one))
    else $error("dropped frame changed setup");
  pulse_once_a: assert property (frame_done |=> !frame_done)
    else $error("frame end pulse too long");
endmodule

bind asr_reg_access asr_reg_access_props u_props (.clk(clk), .rst(rst),
  .output_wire_count(output_wire_count), .setup_one(setup_one),
  .rolling_average_enable(rolling_average_enable), .averaging_ratio(averaging_ratio),
  .averaging_active(averaging_active), .averaging_shift(averaging_shift),
  .crc_in_enable(crc_in_enable), .crc_out_enable(crc_out_enable),
  .alarm_on_secondary(alarm_on_secondary), .resolution_boost(resolution_boost),
  .reference_source(reference_source), .power_down_select(power_down_select),
  .frame_done(frame_done), .frame_ignored(frame_ignored));

// ==== test/test_adc_spi_register_access.sv ====
// self-checking bench for the serial register access block
`timescale 1ns/1ps
module test_adc_spi_register_access import asr_pkg::*;;
  logic clk, rst, sclk, cs_n, sdi, pdo, sob, owc, alarm_level, fd, fi, ign;
  logic avg_act, boost, crc_in, crc_out, alarm_sec, ref_src, pdn;
  logic [15:0] conv_a, conv_b;
  logic [11:0] setup_one;
  logic [1:0] avg_shift;
  logic [31:0] ra, rb;
  int n_errors = 0;
  int n_tests = 0;

  // 200 MHz core clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  asr_reg_access u_dut (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .primary_data_out(pdo), .secondary_out_or_alarm(sob), .output_wire_count(owc),
    .alarm_level(alarm_level), .conv_a(conv_a), .conv_b(conv_b), .setup_one(setup_one),
    .rolling_average_enable(), .averaging_ratio(), .averaging_active(avg_act),
    .averaging_shift(avg_shift), .crc_in_enable(crc_in), .crc_out_enable(crc_out),
    .alarm_on_secondary(alarm_sec), .resolution_boost(boost), .reference_source(ref_src),
    .power_down_select(pdn), .frame_done(fd), .frame_ignored(fi));
  asr_host_model u_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .primary_data_out(pdo),
    .secondary_out_or_alarm(sob));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // bench-side crc, msb first, independent of the design
  function automatic logic [7:0] crc8(input logic [31:0] d, input int n);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = n - 1; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
    return c;
  endfunction

  // one frame, bounded wait for its end pulse, then an idle gap
  task automatic frm(input logic [23:0] w, input int n);
    int k;
    u_host.xfer(w, n, ra, rb);
    for (k = 0; k < 40 && fd !== 1'b1; k++) @(negedge clk);
    if (k == 40) begin
      n_errors++;
      final_report();
    end
    ign = fi;
    repeat (10) @(negedge clk);
  endtask

  task automatic wr(input logic [11:0] d);
    frm({4'h9, d, 8'h00}, 16);
  endtask

  initial begin
    rst <= 1'b1;
    owc <= 1'b0;
    alarm_level <= 1'b0;
    conv_a <= 16'hA5C3;
    conv_b <= 16'h3C5A;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk(setup_one, 12'h000);
    frm(24'h100000, 16);
    frm(24'h000000, 24);
    chk(ra[23:0], 24'h100000);
    // other selectors: writes dropped, reads give conversions
    for (int s = 0; s < 8; s++) begin
      if (s != 1) begin
        frm({1'b1, s[2:0], 12'hFDF, 8'h00}, 16);
        chk(setup_one, 12'h000);
        frm({1'b0, s[2:0], 20'hFFFFF}, 16);
        frm(24'h000000, 16);
        chk({ra[15:0], rb[15:0]}, {conv_a, conv_b});
      end
    end
    wr(12'hFFF);
    chk({ign, setup_one}, 13'h1000);
    wr(12'hFDF);
    chk(setup_one, 12'h3DF);
    chk({avg_act, boost, crc_out, ref_src, pdn, alarm_sec}, 6'b011110);
    frm(24'h100000, 16);
    frm(24'h000000, 24);
    chk(ra[23:0], {16'h13DF, crc8(32'h13DF, 16)});
    chk(rb[23:0], 24'h000000);
    frm(24'h000000, 24);
    chk(ra[23:0], {conv_a, crc8({16'h0, conv_a}, 16)});
    chk(rb[23:0], {conv_b, crc8({16'h0, conv_b}, 16)});
    // one-wire mode moves all data to the primary pin
    owc <= 1'b1;
    alarm_level <= 1'b1;
    frm(24'h000000, 16);
    frm(24'h000000, 32);
    chk(ra, {conv_a, conv_b});
    chk({alarm_sec, rb}, {1'b1, 32'hFFFFFFFF});
    owc <= 1'b0;
    // every ratio code with averaging and boost requested
    for (int r = 0; r < 8; r++) begin
      wr({3'b001, r[2:0], 6'b000100});
      chk({avg_act, avg_shift, boost},
        {r inside {[1:3]}, (r < 4) ? r[1:0] : 2'b00, r != 0});
    end
    frm({16'h9020, crc8(32'h9020, 16)}, 24);
    chk({ign, crc_in}, 2'b01);
    wr(12'h000);
    chk({ign, crc_in}, 2'b11);
    frm({16'h9000, crc8(32'h9000, 16)}, 24);
    chk({ign, crc_in, setup_one}, 14'h0000);
    frm(24'h9FFF00, 12);
    chk({ign, setup_one}, 13'h1000);
    final_report();
  end
endmodule

// ==== verilog/asr_crc8.sv ====
// combinational crc-8 over a word, msb first
`timescale 1ns/1ps
module asr_crc8 import asr_pkg::*; #(
  parameter int W = 16
) (
  input wire logic [W-1:0] data,
  output logic [7:0] crc
);
  // bitwise long division; zero seed so leading zeros change nothing
  always_comb begin
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = W - 1; i >= 0; i--) begin
      if (c[7] ^ data[i]) begin
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    crc = c;
  end
endmodule

// ==== verilog/asr_reg_access.sv ====
// serial command decode and first setup register of a dual sampling converter
`timescale 1ns/1ps
module asr_reg_access import asr_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic primary_data_out,
  output logic secondary_out_or_alarm,
  input wire logic output_wire_count,
  input wire logic alarm_level,
  input wire logic [15:0] conv_a,
  input wire logic [15:0] conv_b,
  output logic [11:0] setup_one,
  output logic rolling_average_enable,
  output logic [2:0] averaging_ratio,
  output logic averaging_active,
  output logic [1:0] averaging_shift,
  output logic crc_in_enable,
  output logic crc_out_enable,
  output logic alarm_on_secondary,
  output logic resolution_boost,
  output logic reference_source,
  output logic power_down_select,
  output logic frame_done,
  output logic frame_ignored
);
  // link domain state
  logic [CNT_W-1:0] bit_cnt_q;
  logic [FRAME_BITS-2:0] rx_q;
  logic [FRAME_BITS-1:0] word_hold_q;
  logic [CRC_BITS-1:0] crc_hold_q;
  logic word_tgl_q;
  logic crc_tgl_q;
  logic [TX_A_W-1:0] sh_a_q;
  logic [TX_B_W-1:0] sh_b_q;

  // core domain state
  logic [2:0] sync_s;
  logic word_prev_q;
  logic crc_prev_q;
  logic cs_prev_q;
  logic got_word_q;
  logic got_crc_q;
  logic [11:0] cfg_q;
  logic [TX_A_W-1:0] tx_a_q;
  logic [TX_B_W-1:0] tx_b_q;
  logic alarm_q;
  logic rae_q;
  logic [2:0] ratio_q;
  logic avg_on_q;
  logic [1:0] avg_shift_q;
  logic crc_in_q;
  logic crc_out_q;
  logic alarm_sel_q;
  logic boost_q;
  logic ref_q;
  logic pdn_q;
  logic done_q;
  logic ign_q;

  // decode terms
  logic word_evt;
  logic crc_evt;
  logic frame_end;
  logic have_word;
  logic have_crc;
  logic cmd_wr;
  logic [2:0] sel;
  logic [11:0] new_cfg;
  logic crc_need;
  logic crc_good;
  asr_action_t act;
  logic [7:0] rx_crc;
  logic [7:0] crc_a;
  logic [7:0] crc_b;
  logic [7:0] crc_a_g;
  logic [7:0] crc_b_g;
  logic [2*FRAME_BITS-1:0] stream_a;
  logic [FRAME_BITS-1:0] readback;
  logic ratio_ok;

  // ------------------------------------------------------------------
  // link side, clocked by the host serial clock
  // ------------------------------------------------------------------

  // bit counter; select high clears it since the clock may stop between frames
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_q <= '0;
    end else if (bit_cnt_q != CNT_MAX) begin
      bit_cnt_q <= bit_cnt_q + 6'h01; // saturates on over-long frames
    end
  end

  // input shift register, msb first
  always_ff @(posedge sclk) begin
    rx_q <= {rx_q[FRAME_BITS-3:0], sdi};
  end

  // command word held at the sixteenth edge, event sent by toggle
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      word_hold_q <= '0;
      word_tgl_q <= 1'b0;
    end else if (!cs_n && bit_cnt_q == CNT_CMD_LAST) begin
      word_hold_q <= {rx_q[FRAME_BITS-2:0], sdi};
      word_tgl_q <= ~word_tgl_q;
    end
  end

  // trailing crc byte, present only on extended frames
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      crc_hold_q <= '0;
      crc_tgl_q <= 1'b0;
    end else if (!cs_n && bit_cnt_q == CNT_CRC_LAST) begin
      crc_hold_q <= {rx_q[CRC_BITS-2:0], sdi};
      crc_tgl_q <= ~crc_tgl_q;
    end
  end

  // output shift: first edge takes the prepared words, later edges shift
  always_ff @(posedge sclk) begin
    if (bit_cnt_q == '0) begin
      sh_a_q <= {tx_a_q[TX_A_W-2:0], 1'b0};
      sh_b_q <= {tx_b_q[TX_B_W-2:0], 1'b0};
    end else begin
      sh_a_q <= {sh_a_q[TX_A_W-2:0], 1'b0};
      sh_b_q <= {sh_b_q[TX_B_W-2:0], 1'b0};
    end
  end

  // msb is ready before the first edge; tx words are quiet during frames
  assign primary_data_out = (bit_cnt_q == '0) ? tx_a_q[TX_A_W-1] : sh_a_q[TX_A_W-1];
  assign secondary_out_or_alarm = alarm_sel_q ? alarm_q :
    ((bit_cnt_q == '0) ? tx_b_q[TX_B_W-1] : sh_b_q[TX_B_W-1]);

  // ------------------------------------------------------------------
  // core side, clocked by clk
  // ------------------------------------------------------------------

  // toggles and select cross by two flops each
  asr_sync #(
    .W(3),
    .RST_VAL(SYNC_RST)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .d({word_tgl_q, crc_tgl_q, cs_n}),
    .q(sync_s)
  );

  assign word_evt = sync_s[2] ^ word_prev_q;
  assign crc_evt = sync_s[1] ^ crc_prev_q;
  assign frame_end = sync_s[0] & ~cs_prev_q;
  // an event landing on the frame-end cycle still counts
  assign have_word = got_word_q | word_evt;
  assign have_crc = got_crc_q | crc_evt;

  // edge history for the synchronised levels
  always_ff @(posedge clk) begin
    if (rst) begin
      word_prev_q <= 1'b0;
      crc_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      word_prev_q <= sync_s[2];
      crc_prev_q <= sync_s[1];
      cs_prev_q <= sync_s[0];
    end
  end

  // per-frame arrival flags, set wins over the frame-end clear
  always_ff @(posedge clk) begin
    if (rst) begin
      got_word_q <= 1'b0;
      got_crc_q <= 1'b0;
    end else begin
      got_word_q <= (got_word_q & ~frame_end) | word_evt;
      got_crc_q <= (got_crc_q & ~frame_end) | crc_evt;
    end
  end

  // hold registers only move sixteen (word) or twenty-four (crc) serial clocks after a frame starts
  asr_crc8 #(
    .W(FRAME_BITS)
  ) u_crc_rx (
    .data(word_hold_q),
    .crc(rx_crc)
  );

  // command decode
  always_comb begin
    cmd_wr = word_hold_q[CMD_POS];
    sel = word_hold_q[SEL_HI:SEL_LO];
    new_cfg = word_hold_q[DATA_W-1:0] & SETUP_ONE_WMASK;
    crc_good = have_crc && (crc_hold_q == rx_crc);
    // guarded mode covers every frame, and so any clearing write
    crc_need = cfg_q[CRC_IN_POS];
    if (cmd_wr && sel == SETUP_ONE_SEL && new_cfg[CRC_IN_POS]) begin
      crc_need = 1'b1;
    end
    if (!have_word) begin
      act = ACT_IGNORE;
    end else if (crc_need && !crc_good) begin
      act = ACT_IGNORE;
    end else if (cmd_wr) begin
      // only the first setup register is writable here
      act = (sel == SETUP_ONE_SEL) ? ACT_WRITE : ACT_CONV;
    end else begin
      // 0, 6, 7 and unlisted selectors read conversions
      act = (sel == SETUP_ONE_SEL) ? ACT_READ : ACT_CONV;
    end
  end

  // first setup register
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_q <= SETUP_ONE_RST;
    end else if (frame_end && act == ACT_WRITE) begin
      cfg_q <= new_cfg;
    end
  end

  // readback word and the two crc sources for the next frame
  assign readback = {SETUP_ONE_TAG, cfg_q};
  always_comb begin
    if (act == ACT_READ) begin
      stream_a = {{FRAME_BITS{1'b0}}, readback};
    end else if (output_wire_count) begin
      stream_a = {conv_a, conv_b};
    end else begin
      stream_a = {{FRAME_BITS{1'b0}}, conv_a};
    end
  end

  asr_crc8 #(
    .W(2 * FRAME_BITS)
  ) u_crc_a (
    .data(stream_a),
    .crc(crc_a)
  );

  asr_crc8 #(
    .W(FRAME_BITS)
  ) u_crc_b (
    .data(conv_b),
    .crc(crc_b)
  );

  // without output crc the trailing bits stay zero
  assign crc_a_g = cfg_q[CRC_OUT_POS] ? crc_a : 8'h00;
  assign crc_b_g = cfg_q[CRC_OUT_POS] ? crc_b : 8'h00;

  // next frame's output, loaded once per frame end
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_a_q <= '0;
      tx_b_q <= '0;
    end else if (frame_end) begin
      if (act == ACT_READ) begin
        tx_a_q <= {readback, crc_a_g, {FRAME_BITS{1'b0}}};
        tx_b_q <= '0;
      end else if (output_wire_count) begin
        tx_a_q <= {conv_a, conv_b, crc_a_g};
        tx_b_q <= '0;
      end else begin
        tx_a_q <= {conv_a, crc_a_g, {FRAME_BITS{1'b0}}};
        tx_b_q <= {conv_b, crc_b_g};
      end
    end
  end

  // ratio codes above x8 switch averaging off
  assign ratio_ok = (cfg_q[RATIO_HI:RATIO_LO] == RATIO_X2) ||
    (cfg_q[RATIO_HI:RATIO_LO] == RATIO_X4) ||
    (cfg_q[RATIO_HI:RATIO_LO] == RATIO_X8);

  // decoded controls, registered so the converter sees clean levels
  always_ff @(posedge clk) begin
    if (rst) begin
      rae_q <= 1'b0;
      ratio_q <= RATIO_OFF;
      avg_on_q <= 1'b0;
      avg_shift_q <= 2'h0;
      crc_in_q <= 1'b0;
      crc_out_q <= 1'b0;
      alarm_sel_q <= 1'b0;
      boost_q <= 1'b0;
      ref_q <= 1'b0;
      pdn_q <= 1'b0;
      alarm_q <= 1'b0;
    end else begin
      rae_q <= cfg_q[RAE_POS];
      ratio_q <= cfg_q[RATIO_HI:RATIO_LO];
      avg_on_q <= cfg_q[RAE_POS] & ratio_ok;
      avg_shift_q <= ratio_ok ? cfg_q[RATIO_LO+1:RATIO_LO] : 2'h0;
      crc_in_q <= cfg_q[CRC_IN_POS];
      crc_out_q <= cfg_q[CRC_OUT_POS];
      alarm_sel_q <= cfg_q[ALARM_EN_POS] & output_wire_count;
      boost_q <= cfg_q[BOOST_POS] & (cfg_q[RATIO_HI:RATIO_LO] != RATIO_OFF);
      ref_q <= cfg_q[REF_POS];
      pdn_q <= cfg_q[PDN_POS];
      alarm_q <= alarm_level;
    end
  end

  // per-frame pulses for the converter core
  always_ff @(posedge clk) begin
    if (rst) begin
      done_q <= 1'b0;
      ign_q <= 1'b0;
    end else begin
      done_q <= frame_end;
      ign_q <= frame_end && act == ACT_IGNORE;
    end
  end

  // output wiring
  assign setup_one = cfg_q;
  assign rolling_average_enable = rae_q;
  assign averaging_ratio = ratio_q;
  assign averaging_active = avg_on_q;
  assign averaging_shift = avg_shift_q;
  assign crc_in_enable = crc_in_q;
  assign crc_out_enable = crc_out_q;
  assign alarm_on_secondary = alarm_sel_q;
  assign resolution_boost = boost_q;
  assign reference_source = ref_q;
  assign power_down_select = pdn_q;
  assign frame_done = done_q;
  assign frame_ignored = ign_q;
endmodule

// ==== verilog/asr_sync.sv ====
// two-stage level synchroniser, one flop pair per bit
`timescale 1ns/1ps
module asr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
